// >>> hdl/sfrc_defs.vh
`ifndef SFRC_DEFS_VH
`define SFRC_DEFS_VH

// ----------------------------------------------------------------------
// read opcodes
// ----------------------------------------------------------------------
`define SFRC_OP_READ4 8'h13
`define SFRC_OP_FAST 8'h0b
`define SFRC_OP_FAST4 8'h0c
`define SFRC_OP_DOUT 8'h3b
`define SFRC_OP_DOUT4 8'h3c
`define SFRC_OP_QOUT 8'h6b
`define SFRC_OP_QOUT4 8'h6c
`define SFRC_OP_DIO 8'hbb

// ----------------------------------------------------------------------
// data phase line widths
// ----------------------------------------------------------------------
`define SFRC_W_SINGLE 2'h0
`define SFRC_W_DUAL 2'h1
`define SFRC_W_QUAD 2'h2

// ----------------------------------------------------------------------
// clock counts
// ----------------------------------------------------------------------
`define SFRC_DUMMY_8 4'h8
`define SFRC_DUMMY_4 4'h4
`define SFRC_DUMMY_0 4'h0
`define SFRC_ACLK_S24 6'h18
`define SFRC_ACLK_S32 6'h20
`define SFRC_ACLK_D24 6'h0c
`define SFRC_ACLK_D32 6'h10
`define SFRC_CMD_LAST 3'h7
`define SFRC_GRP_LAST_S 3'h7
`define SFRC_GRP_LAST_D 3'h3
`define SFRC_GRP_LAST_Q 3'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SFRC_PIN_RST 6'h02
`define SFRC_LINES_RST 4'h0
`define SFRC_ADDR_RST 32'h00000000
`define SFRC_BYTE_RST 8'h00

`endif

// >>> hdl/sfrc_sync.v
`timescale 1ns/100ps

module sfrc_sync #(
    parameter integer W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // pins
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

// ----------------------------------------------------------------------
// two flops per bit, the first read only by the second
// ----------------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
        reg meta_q;
        reg sync_q;
        always @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
                meta_q <= RST_VAL[g];
                sync_q <= RST_VAL[g];
            end else begin
                meta_q <= async_i[g];
                sync_q <= meta_q;
            end
        end
        assign sync_o[g] = sync_q;
    end
endgenerate

endmodule // sfrc_sync

// >>> hdl/sfrc_opdec.v
`timescale 1ns/100ps
`include "sfrc_defs.vh"

module sfrc_opdec (
    // opcode in
    input wire [7:0] opcode_i,
    // attributes out
    output reg known_o,
    output reg force32_o,
    output reg need_std_o,
    output reg need_qe_o,
    output reg addr_dual_o,
    output reg mode_bits_o,
    output reg [3:0] dummy_o,
    output reg [1:0] width_o
);

// ----------------------------------------------------------------------
// opcode table
// ----------------------------------------------------------------------
always @* begin
    known_o = 1'b1;
    force32_o = 1'b0;
    need_std_o = 1'b0;
    need_qe_o = 1'b0;
    addr_dual_o = 1'b0;
    mode_bits_o = 1'b0;
    dummy_o = `SFRC_DUMMY_8;
    width_o = `SFRC_W_SINGLE;
    case (opcode_i)
        `SFRC_OP_READ4: begin
            force32_o = 1'b1;
            need_std_o = 1'b1;
            dummy_o = `SFRC_DUMMY_0;
        end
        `SFRC_OP_FAST: begin
            dummy_o = `SFRC_DUMMY_8;
        end
        `SFRC_OP_FAST4: begin
            force32_o = 1'b1;
            need_std_o = 1'b1;
        end
        `SFRC_OP_DOUT: begin
            width_o = `SFRC_W_DUAL;
            dummy_o = `SFRC_DUMMY_8;
        end
        `SFRC_OP_DOUT4: begin
            width_o = `SFRC_W_DUAL;
            force32_o = 1'b1;
            need_std_o = 1'b1;
        end
        `SFRC_OP_QOUT: begin
            width_o = `SFRC_W_QUAD;
            need_qe_o = 1'b1;
            dummy_o = `SFRC_DUMMY_8;
        end
        `SFRC_OP_QOUT4: begin
            width_o = `SFRC_W_QUAD;
            need_qe_o = 1'b1;
            force32_o = 1'b1;
            need_std_o = 1'b1;
        end
        `SFRC_OP_DIO: begin
            width_o = `SFRC_W_DUAL;
            addr_dual_o = 1'b1;
            mode_bits_o = 1'b1;
            dummy_o = `SFRC_DUMMY_4;
        end
        default: begin
            known_o = 1'b0;
        end
    endcase
end

endmodule // sfrc_opdec

// >>> hdl/sfrc_read_top.v
`timescale 1ns/100ps
`include "sfrc_defs.vh"

// Functional notes
// - opcode 13h always takes 32-bit address
// - forced 32-bit read ignored while busy
// - 13h accepted only in standard mode
// - 0Bh has eight dummy clocks, output ignored
// - address 24 or 32 bits by mode
// - 0Ch is 0Bh with 32-bit address
// - 3Bh data on two lines
// - 3Bh has eight dummy clocks
// - 3Ch is 3Bh with 32-bit address
// - 6Bh data on four lines
// - 6Bh refused unless quad enable set
// - 6Bh has eight dummy clocks
// - 6Ch is 6Bh with 32-bit address
// - BBh address two bits per clock
// - BBh has four dummy clocks
// - sample rising, shift falling, MSB first
// - address advances after each byte
// - chip select high ends read, release lines
// - 24-bit address takes extended address byte

module sfrc_read_top (
    // clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // spi pins from the host
    input wire spi_sclk_i,
    input wire spi_cs_n_i,
    input wire [3:0] data_line_i,
    output reg [3:0] data_line_o,
    output reg [3:0] data_line_oe_o,
    // device state
    input wire busy_i,
    input wire quad_line_enable_i,
    input wire addr_mode_4byte_i,
    input wire spi_std_mode_i,
    input wire [7:0] ext_addr_i,
    // array read port
    output reg mem_rd_o,
    output reg [31:0] mem_addr_o,
    input wire [7:0] mem_data_i,
    // status
    output wire rd_active_o,
    output wire rd_ignored_o,
    output wire [7:0] continuous_mode_bits_o
);

// ----------------------------------------------------------------------
// states
// ----------------------------------------------------------------------
localparam [2:0] ST_CMD = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_DUMMY = 3'h2;
localparam [2:0] ST_DATA = 3'h3;
localparam [2:0] ST_IGN = 3'h4;

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
// last group index of a byte for a given width
function [2:0] grp_last;
    input [1:0] w;
    begin
        case (w)
            `SFRC_W_DUAL: grp_last = `SFRC_GRP_LAST_D;
            `SFRC_W_QUAD: grp_last = `SFRC_GRP_LAST_Q;
            default: grp_last = `SFRC_GRP_LAST_S;
        endcase
    end
endfunction

// drive pattern {oe, data} for the top bits of a byte
function [7:0] lines_of;
    input [1:0] w;
    input [7:0] b;
    begin
        case (w)
            `SFRC_W_DUAL: lines_of = {4'h3, 2'h0, b[7], b[6]};
            `SFRC_W_QUAD: lines_of = {4'hf, b[7:4]};
            default: lines_of = {4'h2, 2'h0, b[7], 1'b0};
        endcase
    end
endfunction

// byte after one group has left
function [7:0] shift_of;
    input [1:0] w;
    input [7:0] b;
    begin
        case (w)
            `SFRC_W_DUAL: shift_of = {b[5:0], 2'h0};
            `SFRC_W_QUAD: shift_of = {b[3:0], 4'h0};
            default: shift_of = {b[6:0], 1'b0};
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------
wire [5:0] pins_s;
wire sclk_s;
wire cs_n_s;
wire [3:0] din_s;

sfrc_sync #(
    .W(6),
    .RST_VAL(`SFRC_PIN_RST)
) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i({data_line_i, spi_cs_n_i, spi_sclk_i}),
    .sync_o(pins_s)
);

assign sclk_s = pins_s[0];
assign cs_n_s = pins_s[1];
assign din_s = pins_s[5:2];

// edges of the host clock; it must run well below the system clock
reg sclk_d_q;
wire sclk_rise;
wire sclk_fall;

always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
        sclk_d_q <= 1'b0;
    end else begin
        sclk_d_q <= sclk_s;
    end
end

assign sclk_rise = sclk_s & ~sclk_d_q;
assign sclk_fall = ~sclk_s & sclk_d_q;

// ----------------------------------------------------------------------
// opcode decode
// ----------------------------------------------------------------------
reg [6:0] cmd_q;
wire [7:0] opcode_w;
wire dec_known;
wire dec_force32;
wire dec_need_std;
wire dec_need_qe;
wire dec_addr_dual;
wire dec_mode_bits;
wire [3:0] dec_dummy;
wire [1:0] dec_width;
wire dec_accept;

assign opcode_w = {cmd_q, din_s[0]};

sfrc_opdec u_dec (
    .opcode_i(opcode_w),
    .known_o(dec_known),
    .force32_o(dec_force32),
    .need_std_o(dec_need_std),
    .need_qe_o(dec_need_qe),
    .addr_dual_o(dec_addr_dual),
    .mode_bits_o(dec_mode_bits),
    .dummy_o(dec_dummy),
    .width_o(dec_width)
);

// a refused read parks in the ignore state and touches nothing else
assign dec_accept = dec_known & ~busy_i
    & (~dec_need_std | spi_std_mode_i)
    & (~dec_need_qe | quad_line_enable_i);

// ----------------------------------------------------------------------
// read sequencer
// ----------------------------------------------------------------------
reg [2:0] state_q;
reg [5:0] cnt_q;
reg [31:0] addr_q;
reg [31:0] rd_addr_q;
reg long_q;
reg dual_addr_q;
reg mode_bits_q;
reg [3:0] dummy_q;
reg [1:0] width_q;
reg [7:0] cont_mode_q;
reg [7:0] cur_q;
reg [7:0] nxt_q;
reg [2:0] grp_q;
reg fetch_q;
wire [5:0] aclk_last;
wire [31:0] addr_nx;
wire [31:0] full_addr;
wire [7:0] src_byte;
wire [7:0] drive_w;

assign aclk_last = dual_addr_q ?
    ((long_q ? `SFRC_ACLK_D32 : `SFRC_ACLK_D24) - 6'h01) :
    ((long_q ? `SFRC_ACLK_S32 : `SFRC_ACLK_S24) - 6'h01);
assign addr_nx = dual_addr_q ? {addr_q[29:0], din_s[1], din_s[0]} :
    {addr_q[30:0], din_s[0]};
assign full_addr = long_q ? addr_nx : {ext_addr_i, addr_nx[23:0]};
assign src_byte = (grp_q == 3'h0) ? nxt_q : cur_q;
assign drive_w = lines_of(width_q, src_byte);

always @(posedge clk_sys_i) begin
    mem_rd_o <= 1'b0;
    if (sys_rst_i | cs_n_s) begin
        state_q <= ST_CMD;
        cnt_q <= 6'h00;
        cmd_q <= 7'h00;
        addr_q <= `SFRC_ADDR_RST;
        rd_addr_q <= `SFRC_ADDR_RST;
        mem_addr_o <= `SFRC_ADDR_RST;
        long_q <= 1'b0;
        dual_addr_q <= 1'b0;
        mode_bits_q <= 1'b0;
        dummy_q <= `SFRC_DUMMY_0;
        width_q <= `SFRC_W_SINGLE;
        cont_mode_q <= `SFRC_BYTE_RST;
        cur_q <= `SFRC_BYTE_RST;
        nxt_q <= `SFRC_BYTE_RST;
        grp_q <= 3'h0;
        fetch_q <= 1'b0;
        data_line_o <= `SFRC_LINES_RST;
        data_line_oe_o <= `SFRC_LINES_RST;
    end else begin
        fetch_q <= 1'b0;
        if (fetch_q) begin
            nxt_q <= mem_data_i;
        end
        case (state_q)
            ST_CMD: begin
                if (sclk_rise) begin
                    cmd_q <= opcode_w[6:0];
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q[2:0] == `SFRC_CMD_LAST) begin
                        cnt_q <= 6'h00;
                        long_q <= dec_force32 | addr_mode_4byte_i;
                        dual_addr_q <= dec_addr_dual;
                        mode_bits_q <= dec_mode_bits;
                        dummy_q <= dec_dummy;
                        width_q <= dec_width;
                        state_q <= dec_accept ? ST_ADDR : ST_IGN;
                    end
                end
            end
            ST_ADDR: begin
                if (sclk_rise) begin
                    addr_q <= addr_nx;
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == aclk_last) begin
                        cnt_q <= 6'h00;
                        if (dummy_q == `SFRC_DUMMY_0) begin
                            state_q <= ST_DATA;
                            mem_rd_o <= 1'b1;
                            mem_addr_o <= full_addr;
                            rd_addr_q <= full_addr + 32'h00000001;
                            fetch_q <= 1'b1;
                        end else begin
                            rd_addr_q <= full_addr;
                            state_q <= ST_DUMMY;
                        end
                    end
                end
            end
            ST_DUMMY: begin
                // line values are ignored here except the mode byte of dual I/O
                if (sclk_rise) begin
                    if (mode_bits_q) begin
                        cont_mode_q <= {cont_mode_q[5:0], din_s[1], din_s[0]};
                    end
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q[3:0] == dummy_q - 4'h1) begin
                        cnt_q <= 6'h00;
                        state_q <= ST_DATA;
                        mem_rd_o <= 1'b1;
                        mem_addr_o <= rd_addr_q;
                        rd_addr_q <= rd_addr_q + 32'h00000001;
                        fetch_q <= 1'b1;
                    end
                end
            end
            ST_DATA: begin
                // lines turn to outputs only at the first falling edge
                if (sclk_fall) begin
                    data_line_oe_o <= drive_w[7:4];
                    data_line_o <= drive_w[3:0];
                    cur_q <= shift_of(width_q, src_byte);
                    if (grp_q == grp_last(width_q)) begin
                        grp_q <= 3'h0;
                    end else begin
                        grp_q <= grp_q + 3'h1;
                    end
                    if (grp_q == 3'h0) begin
                        mem_rd_o <= 1'b1;
                        mem_addr_o <= rd_addr_q;
                        rd_addr_q <= rd_addr_q + 32'h00000001;
                        fetch_q <= 1'b1;
                    end
                end
            end
            ST_IGN: begin
                cnt_q <= 6'h00;
            end
            default: begin
                state_q <= ST_IGN;
            end
        endcase
    end
end

// ----------------------------------------------------------------------
// status
// ----------------------------------------------------------------------
assign rd_active_o = (state_q == ST_DATA);
assign rd_ignored_o = (state_q == ST_IGN);
assign continuous_mode_bits_o = cont_mode_q;

endmodule // sfrc_read_top

// >>> sim/sfrc_read_top_properties.sv
`timescale 1ns/100ps

module sfrc_read_top_properties (
    // clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // pins
    input wire spi_sclk_i,
    input wire spi_cs_n_i,
    input wire [3:0] data_line_o,
    input wire [3:0] data_line_oe_o,
    // array and status
    input wire mem_rd_o,
    input wire [31:0] mem_addr_o,
    input wire rd_active_o,
    input wire rd_ignored_o
);
    // ------
    // last fetch address, forgotten between frames
    // ------
    reg seen_q;
    reg [31:0] last_q;
    always @(posedge clk_sys_i) begin
        if (sys_rst_i || spi_cs_n_i) begin
            seen_q <= 1'b0;
            last_q <= 32'h00000000;
        end else if (mem_rd_o) begin
            seen_q <= 1'b1;
            last_q <= mem_addr_o;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_cs_up;
        !spi_cs_n_i ##1 spi_cs_n_i;
    endsequence
    // pin passes two flops, so allow one spare cycle
    sequence s_lines_free;
        ##[1:4] (data_line_oe_o == 4'h0 && !rd_active_o);
    endsequence

    chk_cs_release: assert property (s_cs_up |-> s_lines_free)
        else $error("lines still driven after chip select rose");
    chk_idle_quiet: assert property (spi_cs_n_i [*4] |->
        data_line_oe_o == 4'h0 && !mem_rd_o)
        else $error("activity while deselected");
    chk_ignore_quiet: assert property (rd_ignored_o |->
        data_line_oe_o == 4'h0 && !mem_rd_o)
        else $error("refused read still drives or fetches");
    chk_ignore_hold: assert property (rd_ignored_o && !spi_cs_n_i |=> rd_ignored_o)
        else $error("refusal dropped inside frame");
    chk_oe_width: assert property (data_line_oe_o != 4'h0 |->
        data_line_oe_o inside {4'h2, 4'h3, 4'hf})
        else $error("illegal enable pattern");
    chk_oe_active: assert property (data_line_oe_o != 4'h0 && !spi_cs_n_i |->
        rd_active_o)
        else $error("lines driven outside data phase");
    chk_fall_shift: assert property (rd_active_o && $changed(data_line_o) |->
        !$past(spi_sclk_i, 1) && !$past(spi_sclk_i, 2))
        else $error("data moved away from a falling clock");
    chk_addr_step: assert property (mem_rd_o && seen_q |->
        mem_addr_o == last_q + 32'h1)
        else $error("fetch address did not step by one");
endmodule // sfrc_read_top_properties

// >>> sim/sfrc_host_model.sv
`timescale 1ns/100ps

module sfrc_host_model #(
    parameter integer HALF = 8
) (
    // clock
    input wire clk_sys_i,
    // resolved lines and device enables
    input wire [3:0] line_i,
    input wire [3:0] dev_oe_i,
    // host pins
    output reg spi_sclk_o = 1'b0,
    output reg spi_cs_n_o = 1'b1,
    output reg [3:0] host_line_o = 4'h0,
    output reg [3:0] host_oe_o = 4'h0
);
    reg [7:0] rx [0:7];
    reg [3:0] oe_seen;
    reg [3:0] smp;

    task hw(input integer n);
        begin
            repeat (n) @(posedge clk_sys_i);
            #1;
        end
    endtask

    // sample just before the rise: data from the previous fall has long settled
    task tick(input [3:0] v, input [3:0] oe, input rel);
        begin
            host_line_o = v;
            host_oe_o = oe;
            hw(HALF);
            smp = line_i;
            oe_seen = oe_seen | dev_oe_i;
            spi_sclk_o = 1'b1;
            hw(HALF - 2);
            if (rel)
                host_oe_o = 4'h0;
            hw(2);
            spi_sclk_o = 1'b0;
        end
    endtask

    task run(input [7:0] op, input [31:0] a, input integer abits, input dual,
             input integer ndum, input [7:0] mode, input [3:0] lanes, input integer nb);
        integer i;
        integer k;
        integer g;
        reg [7:0] b;
        begin
            oe_seen = 4'h0;
            b = 8'h00;
            spi_cs_n_o = 1'b0;
            hw(HALF);
            for (i = 7; i >= 0; i = i - 1)
                tick({3'h0, op[i]}, 4'h1, 1'b0);
            for (i = abits - 1; i >= 0; i = i - (dual ? 2 : 1))
                if (dual)
                    tick({2'h0, a[i], a[i-1]}, 4'h3, ndum == 0 && i == 1);
                else
                    tick({3'h0, a[i]}, 4'h1, ndum == 0 && i == 0);
            for (i = 0; i < ndum; i = i + 1)
                if (dual)
                    tick({2'h0, mode[7-2*i], mode[6-2*i]}, 4'h3, i == ndum - 1);
                else
                    tick(4'h0, 4'h0, 1'b0);
            for (k = 0; k < nb; k = k + 1) begin
                for (g = 0; g < 8; g = g + (lanes == 4'hf ? 4 : lanes == 4'h3 ? 2 : 1)) begin
                    tick(4'h0, 4'h0, 1'b0);
                    if (lanes == 4'hf)
                        b = {b[3:0], smp};
                    else if (lanes == 4'h3)
                        b = {b[5:0], smp[1:0]};
                    else
                        b = {b[6:0], smp[1]};
                end
                rx[k] = b;
            end
        end
    endtask

    task stop;
        begin
            hw(HALF);
            spi_cs_n_o = 1'b1;
            host_oe_o = 4'h0;
            hw(2 * HALF);
        end
    endtask
endmodule // sfrc_host_model

// >>> sim/sfrc_read_top_tb.sv
`timescale 1ns/100ps
`include "sfrc_defs.vh"

module sfrc_read_top_tb;
    // ------
    // signals
    // ------
    reg clk_sys_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg busy_i = 1'b0;
    reg quad_line_enable_i = 1'b1;
    reg addr_mode_4byte_i = 1'b0;
    reg spi_std_mode_i = 1'b1;
    reg [7:0] ext_addr_i = 8'h00;
    reg [7:0] mem_data_i = 8'h00;
    reg [3:0] flt_q = 4'h5;
    reg [31:0] r;
    wire spi_sclk_i;
    wire spi_cs_n_i;
    wire [3:0] host_line;
    wire [3:0] host_oe;
    wire [3:0] data_line_i;
    wire [3:0] data_line_o;
    wire [3:0] data_line_oe_o;
    wire mem_rd_o;
    wire [31:0] mem_addr_o;
    wire rd_active_o;
    wire rd_ignored_o;
    wire [7:0] continuous_mode_bits_o;
    wire [63:0] op_list = {`SFRC_OP_READ4, `SFRC_OP_FAST, `SFRC_OP_FAST4, `SFRC_OP_DOUT,
        `SFRC_OP_DOUT4, `SFRC_OP_QOUT, `SFRC_OP_QOUT4, `SFRC_OP_DIO};
    integer mismatches = 0;
    integer n_compared = 0;
    integer seed = 91884;
    integer cyc = 0;
    integer i;
    integer j;

    always #2.5 clk_sys_i = ~clk_sys_i;

    // released lines flip every cycle so a stale value can never match
    assign data_line_i = (data_line_oe_o & data_line_o) | (~data_line_oe_o & host_oe & host_line)
        | (~data_line_oe_o & ~host_oe & flt_q);

    sfrc_read_top i_dut (.clk_sys_i, .sys_rst_i, .spi_sclk_i, .spi_cs_n_i, .data_line_i,
        .data_line_o, .data_line_oe_o, .busy_i, .quad_line_enable_i, .addr_mode_4byte_i,
        .spi_std_mode_i, .ext_addr_i, .mem_rd_o, .mem_addr_o, .mem_data_i, .rd_active_o,
        .rd_ignored_o, .continuous_mode_bits_o);
    sfrc_host_model i_host (.clk_sys_i, .line_i(data_line_i), .dev_oe_i(data_line_oe_o),
        .spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i), .host_line_o(host_line),
        .host_oe_o(host_oe));

    // ------
    // expectations
    // ------
    function [7:0] mem_byte(input [31:0] a);
        mem_byte = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ {a[2:0], 5'h0b};
    endfunction
    function f32(input [7:0] op);
        f32 = op == `SFRC_OP_READ4 || op == `SFRC_OP_FAST4 || op == `SFRC_OP_DOUT4
            || op == `SFRC_OP_QOUT4;
    endfunction
    function [3:0] lanes(input [7:0] op);
        case (op)
            `SFRC_OP_DOUT, `SFRC_OP_DOUT4, `SFRC_OP_DIO: lanes = 4'h3;
            `SFRC_OP_QOUT, `SFRC_OP_QOUT4: lanes = 4'hf;
            `SFRC_OP_READ4, `SFRC_OP_FAST, `SFRC_OP_FAST4: lanes = 4'h2;
            default: lanes = 4'h0;
        endcase
    endfunction
    function [31:0] rnd();
        rnd = $random(seed);
    endfunction

    // the design takes array data at the edge that ends its fetch strobe, so answer at once
    always @(mem_addr_o)
        mem_data_i <= #1 mem_byte(mem_addr_o);

    always @(posedge clk_sys_i) begin
        flt_q <= ~flt_q;
        cyc = cyc + 1;
        if (cyc == 100000) begin
            mismatches = mismatches + 1;
            end_sim;
        end
    end

    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task do_read(input [7:0] op, input [31:0] a, input integer nb);
        reg refuse;
        reg w32;
        reg [31:0] base;
        reg [7:0] mode;
        integer k;
        begin
            r = rnd();
            mode = {4'hf, r[3:0]};
            w32 = f32(op) || addr_mode_4byte_i;
            refuse = lanes(op) == 4'h0 || busy_i || (f32(op) && !spi_std_mode_i)
                || ((op == `SFRC_OP_QOUT || op == `SFRC_OP_QOUT4) && !quad_line_enable_i);
            base = w32 ? a : {ext_addr_i, a[23:0]};
            i_host.run(op, a, w32 ? 32 : 24, op == `SFRC_OP_DIO,
                op == `SFRC_OP_READ4 ? 0 : op == `SFRC_OP_DIO ? 4 : 8, mode, lanes(op), nb);
            check("ignored", rd_ignored_o, refuse);
            check("enables", i_host.oe_seen, refuse ? 4'h0 : lanes(op));
            for (k = 0; k < nb; k = k + 1)
                if (!refuse)
                    check("data", i_host.rx[k], mem_byte(base + k));
            if (!refuse && op == `SFRC_OP_DIO)
                check("mode", continuous_mode_bits_o, mode);
            i_host.stop;
            $display("test op %h addr %h done", op, a);
        end
    endtask

    task end_sim;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // ------
    // main sequence
    // ------
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        #1;
        for (i = 0; i < 16; i = i + 1) begin
            r = rnd();
            addr_mode_4byte_i = i[3];
            ext_addr_i = r[7:0];
            do_read(op_list[8*(i%8) +: 8], rnd(), 2);
        end
        do_read(`SFRC_OP_FAST, 32'hffffffff, 2);
        for (j = 0; j < 3; j = j + 1) begin
            spi_std_mode_i = j != 0;
            quad_line_enable_i = j != 1;
            busy_i = j == 2;
            for (i = 0; i < 8; i = i + 1)
                do_read(op_list[8*i +: 8], rnd(), 1);
        end
        busy_i = 1'b0;
        do_read(8'h03, rnd(), 1);
        do_read(8'h9f, rnd(), 1);
        for (i = 0; i < 10; i = i + 1) begin
            r = rnd();
            addr_mode_4byte_i = r[8];
            ext_addr_i = r[7:0];
            do_read(op_list[8*r[11:9] +: 8], rnd(), 1 + r[13:12] % 3);
        end
        end_sim;
    end
endmodule // sfrc_read_top_tb

bind sfrc_read_top sfrc_read_top_properties i_chk (
    .clk_sys_i, .sys_rst_i, .spi_sclk_i, .spi_cs_n_i, .data_line_o, .data_line_oe_o,
    .mem_rd_o, .mem_addr_o, .rd_active_o, .rd_ignored_o
);
